// >>> bawd_cfg.svh
// Timing counts, encodings and restart pulse length for the boot and application watchdog.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef BAWD_CFG_SVH
`define BAWD_CFG_SVH
// ----------------------------------------------------------------------------
// Clock and prescaler
// ----------------------------------------------------------------------------
`define BAWD_CLK_HZ        40000000
`define BAWD_SECOND_NS     1000000000
`define BAWD_CLK_PERIOD_NS 25
`define BAWD_TICK_CYCLES   (`BAWD_SECOND_NS / `BAWD_CLK_PERIOD_NS)
// ----------------------------------------------------------------------------
// Boot modes, service port, control codes
// ----------------------------------------------------------------------------
`define BAWD_BOOT_OFF      2'h0
`define BAWD_BOOT_30       2'h1
`define BAWD_BOOT_60       2'h2
`define BAWD_BOOT_90       2'h3
`define BAWD_BOOT_30_S     8'h1e
`define BAWD_BOOT_60_S     8'h3c
`define BAWD_BOOT_90_S     8'h5a
`define BAWD_SERVICE_PORT  16'h0201
`define BAWD_CTL_DISABLE   8'h00
`define BAWD_CTL_ENABLE    8'h01
`define BAWD_ACT_RESTART   1'h0
`define BAWD_ACT_NMI       1'h1
`define BAWD_RESTART_CYCLES 8'h10
`endif

// >>> bawd_pkg.sv
// Types shared by the watchdog files.
// Assumes bawd_cfg.svh sits beside it.
`include "bawd_cfg.svh"
package bawd_pkg;
  typedef logic [7:0] bawd_sec_t;
  // One I/O cycle seen by the watchdog.
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } bawd_io_s;
  // One firmware control command.
  typedef struct packed {
    logic      valid;
    logic [7:0] code;
    bawd_sec_t secs;
  } bawd_cmd_s;
  typedef enum logic [1:0] {
    BAWD_IDLE  = 2'b00,
    BAWD_COUNT = 2'b01,
    BAWD_FIRE  = 2'b11
  } bawd_state_e;
endpackage

// >>> bawd_prescaler.sv
// Seconds prescaler: one-cycle tick per second of system clock.
// Assumes clk at the rate in bawd_cfg.svh; restarted by clear.
`include "bawd_cfg.svh"
module bawd_prescaler #(
  parameter int unsigned TICK_CYCLES = `BAWD_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  output logic      tick
);
  localparam int W = $clog2(TICK_CYCLES);
  logic [W-1:0] cnt_reg;
  // Tick is raised one count before the wrap, so a second needs two cycles at least.
  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("bawd_prescaler: TICK_CYCLES must be at least 2");
  end
  // ----------------------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------------------
  // Clear aligns a fresh full second to each service so the timeout is never short.
  always_ff @(posedge clk) begin
    if (rst || clear || cnt_reg == W'(TICK_CYCLES - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  // Tick marks the last cycle of each second.
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == W'(TICK_CYCLES - 2));
    end
  end
endmodule

// >>> bawd_tb.sv
// Self-checking bench for the boot and application watchdog, driving its ports directly.
// Assumes the watchdog package and configuration header are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bawd_pkg::*;
  // --------------------------------------------------------------------------
  // Shortened counts so that whole seconds last a few cycles
  // --------------------------------------------------------------------------
  localparam int TK    = 10;
  localparam int RP    = 4;
  localparam int LIMIT = 20000;
  logic            clk;
  logic            rst;
  logic [1:0]      boot_mode_pin;
  logic            timeout_action_jumper;
  bawd_io_s        io;
  bawd_cmd_s       cmd;
  logic            sys_restart;
  logic            wd_nmi;
  logic            wd_enabled;
  logic [7:0]      secs_left;
  int              n_mismatch;
  int              n_checks;
  int              cyc;
  int              n_exp;
  logic            act;
  bawd_watchdog #(.TICK_CYCLES(TK), .RESTART_CYCLES(RP)) dut_u (
    .clk                   (clk),
    .rst                   (rst),
    .boot_mode_pin         (boot_mode_pin),
    .timeout_action_jumper (timeout_action_jumper),
    .io                    (io),
    .cmd                   (cmd),
    .sys_restart           (sys_restart),
    .wd_nmi                (wd_nmi),
    .wd_enabled            (wd_enabled),
    .secs_left             (secs_left)
  );
  // The clock toggles every half period of 25 ns.
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Cuts a hang short; the ceiling is well above the longest expected run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  // Inputs change on falling edges so each rising edge samples settled values.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR t=%0t %s", $time, msg);
    end
  endtask
  task automatic send(input logic [7:0] code, input logic [7:0] secs);
    cmd = '{valid: 1'b1, code: code, secs: secs};
    tick(1);
    cmd.valid = 1'b0;
  endtask
  task automatic svc(input logic [15:0] addr);
    io = '{rd: 1'b1, addr: addr};
    tick(1);
    io.rd = 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] mode);
    boot_mode_pin = mode;
    rst = 1'b1;
    tick(8);
    chk(sys_restart === 1'b0 && wd_nmi === 1'b0 && wd_enabled === 1'b0, "outputs in reset");
    rst = 1'b0;
  endtask
  // Waits for expiry about e cycles away, then checks the action and its length.
  task automatic expire(input int e, input logic a);
    int c;
    int w;
    c = 0;
    w = 0;
    while (sys_restart !== 1'b1 && wd_nmi !== 1'b1 && c < 3000) begin
      tick(1);
      c++;
    end
    chk(c >= e - 3 && c <= e + 4, "expiry time");
    chk(a ? (wd_nmi === 1'b1 && sys_restart === 1'b0)
          : (sys_restart === 1'b1 && wd_nmi === 1'b0), "expiry action");
    while ((sys_restart === 1'b1 || wd_nmi === 1'b1) && w < 300) begin
      tick(1);
      w++;
    end
    chk(w == RP, "action pulse length");
    tick(2);
    chk(wd_enabled === 1'b0, "idle after firing");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    rst = 1'b1;
    boot_mode_pin = 2'h0;
    timeout_action_jumper = 1'b0;
    io = '{rd: 1'b0, addr: 16'h0000};
    cmd = '{valid: 1'b0, code: 8'h00, secs: 8'h00};
    void'($urandom(68));
    // Unsupervised boot leaves the countdown stopped.
    do_reset(2'h0);
    tick(20);
    chk(wd_enabled === 1'b0 && sys_restart === 1'b0, "boot off stays idle");
    $display("test boot_off done");
    // Each supervised boot mode loads its own timeout; the first is run to expiry.
    for (int m = 1; m <= 3; m++) begin
      act = 1'(m - 1);
      timeout_action_jumper = act;
      do_reset(2'(m));
      tick(12);
      chk(wd_enabled === 1'b1 && secs_left === 8'(30 * m), "boot timeout");
      if (m == 1) expire(30 * TK - 6, act);
    end
    $display("test boot_modes done");
    // Servicing through the port holds off expiry; a neighbour address does not.
    do_reset(2'h0);
    tick(10);
    n_exp = $urandom_range(40, 5);
    act = 1'($urandom);
    timeout_action_jumper = act;
    send(8'h01, 8'(n_exp));
    tick(4 + 2 * TK);
    chk(secs_left === 8'(n_exp - 2), "countdown per second");
    repeat (8) begin
      tick(6);
      svc(16'h0201);
    end
    tick(3);
    chk(secs_left === 8'(n_exp) && sys_restart === 1'b0 && wd_nmi === 1'b0, "reload");
    svc(16'h0200);
    expire(n_exp * TK - 4, act);
    $display("test service done");
    // Disabling stops supervision; unknown codes are ignored.
    timeout_action_jumper = 1'b0;
    send(8'h01, 8'h05);
    tick(25);
    send(8'h00, 8'h05);
    tick(2);
    chk(wd_enabled === 1'b0, "disable");
    send(8'h02, 8'h05);
    tick(8 * TK);
    chk(wd_enabled === 1'b0 && sys_restart === 1'b0 && wd_nmi === 1'b0, "held");
    chk(secs_left === 8'h03, "count held while disabled");
    $display("test disable done");
    // A zero seconds count behaves as the shortest timeout, the full count as longest.
    // An unknown code in the expiry cycle must not cancel the action.
    send(8'h01, 8'h00);
    tick(TK - 1);
    send(8'h02, 8'h00);
    expire(0, 1'b0);
    timeout_action_jumper = 1'b1;
    send(8'h01, 8'hff);
    tick(5);
    chk(secs_left === 8'hff && wd_enabled === 1'b1, "full count");
    expire(255 * TK - 5, 1'b1);
    $display("test limits done");
    results();
  end
endmodule

// >>> bawd_watchdog.sv
// Boot and application watchdog: seconds countdown, service port, firmware control.
// Assumes the I/O cycle and command arrive synchronous to clk; straps are pins.
//
// Notes on behaviour
// - boot mode off, or 30, 60, 90 seconds.
// - any read of port 201h reloads countdown.
// - expiry performs the jumper-selected action.
// - programmed timeout is 1 to 255 seconds.
// - code 00 disables, code 01 enables.
`include "bawd_cfg.svh"
module bawd_watchdog
  import bawd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES    = `BAWD_TICK_CYCLES,
  parameter int unsigned RESTART_CYCLES = `BAWD_RESTART_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [1:0]        boot_mode_pin,
  input  wire logic              timeout_action_jumper,
  input  wire bawd_pkg::bawd_io_s  io,
  input  wire bawd_pkg::bawd_cmd_s cmd,
  output logic                   sys_restart,
  output logic                   wd_nmi,
  output logic                   wd_enabled,
  output logic [7:0]             secs_left
);
  import bawd_pkg::*;

  // The pulse length is held in an eight-bit down counter.
  if (RESTART_CYCLES < 1 || RESTART_CYCLES > 255) begin : g_restart_check
    $error("bawd_watchdog: bad RESTART_CYCLES");
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // Three stages; a level counts only once stages two and three agree.
  logic [1:0] mode_s1_reg, mode_s2_reg, mode_s3_reg, mode_reg;
  logic       act_s1_reg, act_s2_reg, act_s3_reg, act_reg;
  always_ff @(posedge clk) begin
    mode_s1_reg <= boot_mode_pin;
    mode_s2_reg <= mode_s1_reg;
    mode_s3_reg <= mode_s2_reg;
    act_s1_reg  <= timeout_action_jumper;
    act_s2_reg  <= act_s1_reg;
    act_s3_reg  <= act_s2_reg;
  end
  always_ff @(posedge clk) begin
    if (mode_s2_reg == mode_s3_reg) mode_reg <= mode_s3_reg;
    if (act_s2_reg == act_s3_reg) act_reg <= act_s3_reg;
  end

  // Boot timeout for a given mode code.
  function automatic bawd_sec_t boot_secs(input logic [1:0] m);
    unique case (m)
      `BAWD_BOOT_30: boot_secs = `BAWD_BOOT_30_S;
      `BAWD_BOOT_60: boot_secs = `BAWD_BOOT_60_S;
      `BAWD_BOOT_90: boot_secs = `BAWD_BOOT_90_S;
      default:       boot_secs = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // Decode of service and commands
  // ----------------------------------------------------------------------------
  logic service;
  logic cmd_en, cmd_dis;
  assign service = io.rd && io.addr == `BAWD_SERVICE_PORT;
  assign cmd_en  = cmd.valid && cmd.code == `BAWD_CTL_ENABLE;
  assign cmd_dis = cmd.valid && cmd.code == `BAWD_CTL_DISABLE;

  logic       tick;
  logic [2:0] arm_cnt_reg;
  logic       boot_arm_reg;
  bawd_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_presc (
    .clk   (clk),
    .rst   (rst),
    .clear (service || cmd_en || boot_arm_reg),
    .tick  (tick)
  );

  // ----------------------------------------------------------------------------
  // Boot arming: strap is caught a few cycles after reset release
  // ----------------------------------------------------------------------------
  // The synchroniser needs four edges to settle, so arming waits for it.
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_cnt_reg  <= 3'h0;
      boot_arm_reg <= 1'b0;
    end else begin
      if (arm_cnt_reg != 3'h5) arm_cnt_reg <= arm_cnt_reg + 3'h1;
      boot_arm_reg <= (arm_cnt_reg == 3'h4);
    end
  end

  // ----------------------------------------------------------------------------
  // Countdown state machine
  // ----------------------------------------------------------------------------
  bawd_state_e state_reg;
  bawd_sec_t   reload_reg;
  bawd_sec_t   count_reg;
  logic [7:0]  fire_cnt_reg;
  logic        expire;
  logic        fire_start;
  assign expire = state_reg == BAWD_COUNT && tick && count_reg == 8'h01 && !service;
  // Besides a service read (excluded in expire), only a decoded command or boot arming outranks expiry; an unknown code must not cancel the pulse,
  // or the machine would enter the firing state with no count to leave it.
  assign fire_start = expire && !boot_arm_reg && !cmd_en && !cmd_dis;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= BAWD_IDLE;
      reload_reg <= 8'h00;
      count_reg  <= 8'h00;
    end else if (boot_arm_reg) begin
      reload_reg <= boot_secs(mode_reg);
      count_reg  <= boot_secs(mode_reg);
      state_reg  <= (mode_reg == `BAWD_BOOT_OFF) ? BAWD_IDLE : BAWD_COUNT;
    end else if (state_reg == BAWD_FIRE) begin
      if (fire_cnt_reg == 8'h01) state_reg <= BAWD_IDLE;
    end else if (cmd_dis) begin
      state_reg <= BAWD_IDLE; // count held, no expiry
    end else if (cmd_en) begin
      // A zero count would be meaningless; it is served as one second.
      reload_reg <= (cmd.secs == 8'h00) ? 8'h01 : cmd.secs;
      count_reg  <= (cmd.secs == 8'h00) ? 8'h01 : cmd.secs;
      state_reg  <= BAWD_COUNT;
    end else if (state_reg == BAWD_COUNT) begin
      if (service) begin
        count_reg <= reload_reg;
      end else if (expire) begin
        count_reg <= 8'h00;
        state_reg <= BAWD_FIRE;
      end else if (tick) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Expiry action, chosen by the jumper
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fire_cnt_reg <= 8'h00;
      sys_restart  <= 1'b0;
      wd_nmi       <= 1'b0;
    end else if (fire_start) begin
      fire_cnt_reg <= 8'(RESTART_CYCLES);
      sys_restart  <= act_reg == `BAWD_ACT_RESTART;
      wd_nmi       <= act_reg == `BAWD_ACT_NMI;
    end else if (fire_cnt_reg != 8'h00) begin
      fire_cnt_reg <= fire_cnt_reg - 8'h01;
      if (fire_cnt_reg == 8'h01) begin
        sys_restart <= 1'b0;
        wd_nmi      <= 1'b0;
      end
    end
  end

  // Status mirrors for the board.
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_enabled <= 1'b0;
      secs_left  <= 8'h00;
    end else begin
      wd_enabled <= state_reg == BAWD_COUNT;
      secs_left  <= count_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_serviced;
    state_reg == BAWD_COUNT && service && !cmd.valid && !boot_arm_reg;
  endsequence
  property p_service_reload;
    @(posedge clk) disable iff (rst) s_serviced |=> count_reg == reload_reg;
  endproperty
  a_service_reload: assert property (p_service_reload) else $error("service did not reload");

  property p_expire_fires;
    @(posedge clk) disable iff (rst)
      fire_start |=> state_reg == BAWD_FIRE ##0 (sys_restart || wd_nmi);
  endproperty
  a_expire_fires: assert property (p_expire_fires) else $error("expiry without action");

  property p_action_jumper;
    @(posedge clk) disable iff (rst) $rose(sys_restart) |-> $past(act_reg) == `BAWD_ACT_RESTART;
  endproperty
  a_action_jumper: assert property (p_action_jumper) else $error("wrong expiry action");

  property p_enable_range;
    @(posedge clk) disable iff (rst) cmd_en && !boot_arm_reg && state_reg != BAWD_FIRE
      |=> reload_reg != 8'h00 && state_reg == BAWD_COUNT;
  endproperty
  a_enable_range: assert property (p_enable_range) else $error("enable gave bad timeout");

  property p_disable_holds;
    @(posedge clk) disable iff (rst) cmd_dis && !boot_arm_reg && state_reg != BAWD_FIRE
      |=> state_reg == BAWD_IDLE ##1 !sys_restart && !wd_nmi;
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("disable did not stop");

  property p_idle_hold;
    @(posedge clk) disable iff (rst) state_reg == BAWD_IDLE && !boot_arm_reg && !cmd.valid
      |=> $stable(count_reg);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved while idle");

  property p_decrement;
    @(posedge clk) disable iff (rst) state_reg == BAWD_COUNT && tick && !service && !cmd.valid
      && !boot_arm_reg && count_reg > 8'h01 |=> count_reg == $past(count_reg) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("countdown step wrong");

  property p_boot_mode;
    @(posedge clk) disable iff (rst) boot_arm_reg |=> reload_reg == boot_secs($past(mode_reg));
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("boot timeout wrong");

  property p_fire_counted;
    @(posedge clk) disable iff (rst) state_reg == BAWD_FIRE |-> fire_cnt_reg != 8'h00;
  endproperty
  a_fire_counted: assert property (p_fire_counted) else $error("firing with no pulse count");
endmodule
